// [hw/fecs_consts.svh]
// Purpose: constants of the flash/eeprom command sequencer
// Assumes: 20 MHz clock, one clock domain
// Notes:   offsets, codes, sizes and timing counts only
`ifndef FECS_CONSTS_SVH
`define FECS_CONSTS_SVH

`define FECS_CLK_HZ        20000000
`define FECS_SECT_KB       16
`define FECS_EE_BURST_MAX  7'h40
// unlock offsets, low twelve bits
`define FECS_ADDR_UNL1     12'h555
`define FECS_ADDR_UNL2     12'haaa
// data codes
`define FECS_D_UNL1        8'haa
`define FECS_D_UNL2        8'h55
`define FECS_D_IDREAD      8'h90
`define FECS_D_PROG        8'ha0
`define FECS_D_ERASE       8'h80
`define FECS_D_SECT        8'h30
`define FECS_D_CHIP        8'h10
`define FECS_D_SUSP        8'hb0
`define FECS_D_RESET       8'hf0
`define FECS_D_SDPOFF      8'h20
`define FECS_D_OTPW        8'hb0
`define FECS_D_PDOWN       8'h30
// power-up write inhibit: 5 ms
`define FECS_PWRUP_MS      5
`define FECS_PWRUP_CYC     ((`FECS_CLK_HZ / 1000) * `FECS_PWRUP_MS)
// inter-byte timeout and erase window
`define FECS_TMO_CYC       2000
`define FECS_SECT_WIN_US   80
`define FECS_SECT_WIN_CYC  ((`FECS_CLK_HZ / 1000000) * `FECS_SECT_WIN_US)
// default busy times
`define FECS_PROG_CYC      200
`define FECS_ERASE_CYC     20000
`define FECS_EEW_CYC       10000

`endif

// [hw/fecs_pkg.sv]
// Purpose: types shared by the sequencer files
// Assumes: nothing
// Notes:   numbers live in fecs_consts.svh
package fecs_pkg;
  // =========================================
  // decoder states, one-hot
  typedef enum logic [7:0] {
    FECS_IDLE  = 8'h01, // read array, awaiting first byte
    FECS_UNL1  = 8'h02, // first unlock seen
    FECS_UNL2  = 8'h04, // second unlock seen, awaiting command
    FECS_ER1   = 8'h08, // erase setup seen
    FECS_ER2   = 8'h10, // erase setup + first unlock
    FECS_ER3   = 8'h20, // erase setup + both unlocks
    FECS_DATA  = 8'h40, // awaiting program data byte(s)
    FECS_HOLD  = 8'h80  // id / protect read hold
  } fecs_state_t;

  // kind of embedded operation handed to the timer
  typedef enum logic [1:0] {
    FECS_OP_PROG  = 2'h0,
    FECS_OP_ERASE = 2'h1,
    FECS_OP_EEW   = 2'h2
  } fecs_op_t;
endpackage

// [hw/fecs_timer.sv]
// Purpose: counter that times an inter-byte gap or a fixed window
// Assumes: restart wins over a running count
// Notes:   expired is a level, high once the count has run out
module fecs_timer
  import fecs_pkg::*;
#(
  parameter int unsigned LIMIT = 2000
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic restart,
  input  wire logic stop,
  output logic      expired
);
  // =========================================
  // count register
  logic [23:0] cnt_q;     // remaining cycles
  logic        run_q;     // timer armed
  wire  [23:0] limitW = 24'(LIMIT);
  wire  [23:0] cntDec = cnt_q - 24'h000001;

  assign expired = run_q && (cnt_q == 24'h000000);

  // restart loads the limit; stop disarms
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= 24'h000000;
      run_q <= 1'b0;
    end else if (restart) begin
      cnt_q <= limitW;
      run_q <= 1'b1;
    end else if (stop) begin
      run_q <= 1'b0;
    end else if (run_q && cnt_q != 24'h000000) begin
      cnt_q <= cntDec;
    end
  end
endmodule

// [hw/fecs_oper.sv]
// Purpose: busy timing of one embedded program/erase/write operation
// Assumes: start only when idle
// Notes:   suspend freezes erase progress, resume continues it
module fecs_oper
  import fecs_pkg::*;
#(
  parameter int unsigned PROG_CYC  = 200,
  parameter int unsigned ERASE_CYC = 20000,
  parameter int unsigned EEW_CYC   = 10000
) (
  input  wire logic     clk,
  input  wire logic     nrst,
  input  wire logic     start,
  input  wire fecs_op_t opKind,
  input  wire logic     extend,
  input  wire logic     suspend,
  input  wire logic     resume,
  output logic          busy,
  output logic          suspended,
  output logic          done
);
  // =========================================
  // operation state
  logic [23:0] cnt_q;    // remaining cycles
  logic        busy_q;   // operation in progress
  logic        susp_q;   // erase suspended
  logic        done_q;   // one-cycle completion pulse
  fecs_op_t    kind_q;   // running operation

  // cycle count for each operation kind
  function automatic logic [23:0] opLen(input fecs_op_t k);
    case (k)
      FECS_OP_PROG:  opLen = 24'(PROG_CYC);
      FECS_OP_ERASE: opLen = 24'(ERASE_CYC);
      default:       opLen = 24'(EEW_CYC);
    endcase
  endfunction

  wire  canSusp = busy_q && kind_q == FECS_OP_ERASE;
  wire  last    = busy_q && !susp_q && cnt_q == 24'h000001;

  assign busy      = busy_q && !susp_q;
  assign suspended = susp_q;
  assign done      = done_q;

  // extend adds one more sector to a running erase
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q  <= 24'h000000;
      busy_q <= 1'b0;
      susp_q <= 1'b0;
      done_q <= 1'b0;
      kind_q <= FECS_OP_PROG;
    end else begin
      done_q <= last;
      if (start && !busy_q) begin
        cnt_q  <= opLen(opKind);
        busy_q <= 1'b1;
        kind_q <= opKind;
      end else if (extend && canSusp) begin
        cnt_q <= cnt_q + opLen(FECS_OP_ERASE);
      end else if (last) begin
        busy_q <= 1'b0;
        cnt_q  <= 24'h000000;
      end else if (busy && cnt_q != 24'h000000) begin
        cnt_q <= cnt_q - 24'h000001;
      end
      if (suspend && canSusp) begin
        susp_q <= 1'b1;
      end else if (resume) begin
        susp_q <= 1'b0;
      end
    end
  end
endmodule

// [hw/fecs_sequencer.sv]
// Purpose: command decoder and status of flash and eeprom arrays
// Assumes: bus strobes synchronous to clk, one cycle each
// Notes:   arrays themselves live outside; this block gates them
// Behaviour
// [R1] eight flash sectors, four eeprom sectors, selects
// [R2] protected sectors refuse program and erase
// [R3] flash sector erase, byte program
// [R4] erase suspend, reads elsewhere, resume
// [R5] eeprom byte/sector write, erase automatic
// [R6] eeprom writes blocked first five ms
// [R7] status low while busy, high otherwise
// [R8] selects formed upstream from product terms
// [R9] plain reads return flash, writes ignored
// [R10] controller polls completion before next operation
// [R11] plain eeprom writes: one to 64 bytes
// [R12] soft protect: plain eeprom writes ignored
// [R13] bytes decoded in order, timeout between
// [R14] flash bad sequence returns to read array
// [R15] eeprom bad byte becomes plain write
// [R16] two unlock cycles prefix every command except the short reset, suspend and resume
// [R17] upper address bits ignored in commands
// [R18] full flash and eeprom command set
// [R19] extra sector confirmations within 80 us
// [R20] sector selects active high
// [R21] id, protect read, error hold until reset
// [R22] inter-byte timeout parameter, restarts each byte
// [R23] status pin driven only when enabled
`include "fecs_consts.svh"
module fecs_sequencer
  import fecs_pkg::*;
#(
  parameter int unsigned TMO_CYC    = `FECS_TMO_CYC,
  parameter int unsigned PWRUP_CYC  = `FECS_PWRUP_CYC,
  parameter int unsigned SWIN_CYC   = `FECS_SECT_WIN_CYC,
  parameter int unsigned ERASE_CYC  = `FECS_ERASE_CYC,
  parameter int unsigned EEW_CYC    = `FECS_EEW_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [15:0] busAddr,
  input  wire logic [7:0]  busWdata,
  input  wire logic        busWr,
  input  wire logic        busRd,
  input  wire logic [7:0]  flashSectorSelects,
  input  wire logic [3:0]  eepromSectorSelects,
  input  wire logic [7:0]  flashProtect,
  input  wire logic [3:0]  eepromProtect,
  input  wire logic [7:0]  arrayRdata,
  input  wire logic [7:0]  idValue,
  input  wire logic        statusPinEnable,
  output logic             flashProgStb,
  output logic             flashEraseStb,
  output logic [7:0]       flashEraseMask,
  output logic             eepromWriteStb,
  output logic [15:0]      arrayAddr,
  output logic [7:0]       arrayWdata,
  output logic [7:0]       busRdata,
  output logic             errorStatusBit,
  output logic             softWriteProtectMode,
  output logic             eepromPowerDown,
  output logic             otpMode,
  output logic             eraseSuspended,
  output logic             statusPinOut,
  output logic             statusPinOe
);
  // =========================================
  // select decode
  wire fsel = |flashSectorSelects;   // active high [R1] [R20]
  wire esel = |eepromSectorSelects;  // active high [R20]
  // [R8] product-term merging is done upstream; one line per sector
  wire [11:0] lowA = busAddr[11:0];  // a15..a12 dropped [R17]
  wire isU1 = lowA == `FECS_ADDR_UNL1 && busWdata == `FECS_D_UNL1;
  wire isU2 = lowA == `FECS_ADDR_UNL2 && busWdata == `FECS_D_UNL2;
  wire at555 = lowA == `FECS_ADDR_UNL1;
  wire fWr  = busWr && fsel;
  wire eWr  = busWr && esel && !fsel;

  // any selected sector protected?
  function automatic logic hitProt(input logic [7:0] sel,
                                   input logic [7:0] prot);
    hitProt = |(sel & prot);
  endfunction

  // =========================================
  // state
  fecs_state_t st_q, st_d;
  logic        arrF_q;        // sequence targets flash
  logic        otpW_q;        // eeprom data goes to otp row
  logic        sdp_q;         // soft write protect
  logic        pdn_q;         // eeprom powered down
  logic        otp_q;         // otp row read mode
  logic        err_q;         // error flag, held until reset
  logic        hold_q;        // id/protect read mode
  logic [6:0]  burst_q;       // eeprom bytes in this event
  logic [7:0]  eraseM_q;      // sectors queued for erase
  logic        pwrOk_q;       // power-up window over
  logic [23:0] pwrCnt_q;      // power-up counter
  logic [7:0]  rd_q;          // registered read data
  logic        progS_q, eraS_q, eeS_q;
  logic [15:0] aA_q;
  logic [7:0]  aD_q;

  wire opBusy, opSusp, opDone;
  wire tmo, swinExp;
  logic    opStart, opExt, opSuspReq, opResReq;
  fecs_op_t opKind;

  // =========================================
  // inter-byte timer: restarts on every accepted byte [R22]
  wire inSeq = st_q != FECS_IDLE && st_q != FECS_HOLD;
  fecs_timer #(.LIMIT(TMO_CYC)) uTmo (
    .clk     (clk),
    .nrst    (nrst),
    .restart (busWr && (fsel || esel)),
    .stop    (!inSeq),
    .expired (tmo)
  );

  // window for extra sector-erase confirmations
  wire sectConf = st_q == FECS_IDLE && fWr && opBusy
                  && busWdata == `FECS_D_SECT && eraseM_q != 8'h00;
  fecs_timer #(.LIMIT(SWIN_CYC)) uWin (
    .clk     (clk),
    .nrst    (nrst),
    .restart (eraS_q || opExt),
    .stop    (opDone),
    .expired (swinExp)
  );

  // embedded operation timing [R3] [R4] [R5]
  fecs_oper #(.ERASE_CYC(ERASE_CYC), .EEW_CYC(EEW_CYC)) uOp (
    .clk       (clk),
    .nrst      (nrst),
    .start     (opStart),
    .opKind    (opKind),
    .extend    (opExt),
    .suspend   (opSuspReq),
    .resume    (opResReq),
    .busy      (opBusy),
    .suspended (opSusp),
    .done      (opDone)
  );

  // =========================================
  // power-up write inhibit [R6]
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwrCnt_q <= 24'h000000;
      pwrOk_q  <= 1'b0;
    end else if (!pwrOk_q) begin
      pwrCnt_q <= pwrCnt_q + 24'h000001;
      pwrOk_q  <= pwrCnt_q == 24'(PWRUP_CYC - 1);
    end
  end

  // =========================================
  // byte classification
  wire cmdPhase  = st_q == FECS_UNL2;
  wire dataPhase = st_q == FECS_DATA;
  wire protF     = hitProt(flashSectorSelects, flashProtect);   // [R2]
  wire protE     = hitProt({4'h0, eepromSectorSelects},
                           {4'h0, eepromProtect});              // [R2]
  wire eeOk      = pwrOk_q && !pdn_q && !protE;                 // [R6]
  wire burstRoom = burst_q < `FECS_EE_BURST_MAX;                // [R11]
  // plain eeprom write outside a sequence, blocked by soft protect
  wire plainEe   = eWr && st_q == FECS_IDLE && !isU1 && !sdp_q
                   && eeOk && burstRoom && !otp_q;       // [R11] [R12]
  // short commands at any address: flash reset, suspend, resume; eeprom return
  wire rstCmd    = fWr && busWdata == `FECS_D_RESET
                   && (st_q == FECS_IDLE || cmdPhase || st_q == FECS_HOLD);
  wire shortSusp = fWr && busWdata == `FECS_D_SUSP && opBusy
                   && eraseM_q != 8'h00;                          // [R4]
  wire shortRes  = fWr && st_q == FECS_IDLE && opSusp
                   && busWdata == `FECS_D_SECT;                   // [R4]
  wire eeReturn  = eWr && st_q == FECS_IDLE
                   && busWdata == `FECS_D_RESET;                  // [R18]

  // =========================================
  // next state of the sequence decoder [R13] [R16]
  always_comb begin
    st_d = st_q;
    case (st_q)
      FECS_IDLE: begin
        if ((fWr || eWr) && isU1 && !opBusy) st_d = FECS_UNL1;  // [R16]
      end
      FECS_UNL1: begin
        if (busWr) st_d = isU2 ? FECS_UNL2 : FECS_IDLE;     // [R14] [R15]
      end
      FECS_UNL2: begin
        if (busWr) begin
          if (busWdata == `FECS_D_RESET) st_d = FECS_IDLE;
          else if (busWdata == `FECS_D_IDREAD && at555) st_d = FECS_HOLD;
          else if (busWdata == `FECS_D_PROG && at555) st_d = FECS_DATA;
          else if (busWdata == `FECS_D_ERASE && at555) st_d = FECS_ER1;
          else if (!arrF_q && busWdata == `FECS_D_OTPW && at555)
            st_d = FECS_DATA;
          else st_d = FECS_IDLE;                            // [R14] [R15]
        end
      end
      FECS_ER1: begin
        if (busWr) st_d = isU1 ? FECS_ER2 : FECS_IDLE;
      end
      FECS_ER2: begin
        if (busWr) st_d = isU2 ? FECS_ER3 : FECS_IDLE;
      end
      FECS_ER3: begin
        if (busWr) st_d = FECS_IDLE;
      end
      FECS_DATA: begin
        // flash takes one byte; eeprom stays until timeout
        if (busWr && arrF_q) st_d = FECS_IDLE;
      end
      FECS_HOLD: begin
        if (rstCmd) st_d = FECS_IDLE;                           // [R21]
      end
      default: st_d = FECS_IDLE;
    endcase
    if (tmo && inSeq) st_d = FECS_IDLE;                 // [R13] [R14]
  end

  // =========================================
  // operation launch
  wire lastEr   = st_q == FECS_ER3 && busWr;
  wire chipEr   = lastEr && arrF_q && busWdata == `FECS_D_CHIP && at555;
  wire sectEr   = lastEr && arrF_q && busWdata == `FECS_D_SECT;
  wire sdpOff   = lastEr && !arrF_q && busWdata == `FECS_D_SDPOFF && at555;
  wire fProg    = dataPhase && arrF_q && fWr;                     // [R3]
  wire eData    = dataPhase && !arrF_q && eWr && burstRoom;       // [R5]
  wire fProgOk  = fProg && !protF && !opSusp;                     // [R2]
  wire chipOk   = chipEr && flashProtect == 8'h00;                // [R2]
  wire sectOk   = sectEr && !protF && !opSusp;                    // [R2]
  // bad byte in an eeprom sequence falls back to a plain write [R15]
  wire eeBad    = eWr && !arrF_q && inSeq && st_d == FECS_IDLE
                  && !dataPhase && !sdpOff && !(cmdPhase
                  && (busWdata == `FECS_D_PDOWN
                  || busWdata == `FECS_D_RESET));
  wire eeWrite  = (plainEe || (eData && !otpW_q)
                  || (eeBad && !sdp_q)) && eeOk;
  // sector select of an extra erase confirmation [R19]
  wire extOk    = sectConf && !swinExp && !protF;

  always_comb begin
    opStart   = 1'b0;
    opKind    = FECS_OP_PROG;
    opExt     = extOk;                                           // [R19]
    opSuspReq = shortSusp;
    opResReq  = shortRes;
    if (fProgOk) begin
      opStart = 1'b1;
    end else if (sectOk || chipOk) begin
      opStart = 1'b1;
      opKind  = FECS_OP_ERASE;
    end else if (busWr && eeWrite) begin
      opStart = 1'b1;
      opKind  = FECS_OP_EEW;
    end
  end

  // =========================================
  // decoder registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q    <= FECS_IDLE;
      arrF_q  <= 1'b0;
      otpW_q  <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == FECS_IDLE && busWr) arrF_q <= fsel;
      if (cmdPhase && busWr) begin
        otpW_q  <= busWdata == `FECS_D_OTPW;
      end
    end
  end

  // mode flags: soft protect, power down, otp read, errors
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sdp_q  <= 1'b0;
      pdn_q  <= 1'b0;
      otp_q  <= 1'b0;
      err_q  <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      if (cmdPhase && eWr && busWdata == `FECS_D_PROG && at555)
        sdp_q <= 1'b1;                                    // [R12] [R18]
      else if (sdpOff)
        sdp_q <= 1'b0;                                         // [R18]
      if (cmdPhase && eWr && busWdata == `FECS_D_PDOWN && at555)
        pdn_q <= 1'b1;                                         // [R18]
      else if (eeReturn)
        pdn_q <= 1'b0;
      if (cmdPhase && eWr && busWdata == `FECS_D_IDREAD && at555)
        otp_q <= 1'b1;                                         // [R18]
      else if (eeReturn)
        otp_q <= 1'b0;
      // refused program or erase raises the error; set beats clear
      if ((fProg && !fProgOk) || (sectEr && !sectOk)
          || (chipEr && !chipOk))
        err_q <= 1'b1;                                         // [R21]
      else if (rstCmd)
        err_q <= 1'b0;                                         // [R21]
      hold_q <= st_d == FECS_HOLD && arrF_q;                   // [R21]
    end
  end

  // erase mask and eeprom burst count
  always_ff @(posedge clk) begin
    if (!nrst) begin
      eraseM_q <= 8'h00;
      burst_q  <= 7'h00;
    end else begin
      if (opDone) eraseM_q <= 8'h00;
      else if (chipOk) eraseM_q <= 8'hff;
      else if (sectOk || extOk)
        eraseM_q <= eraseM_q | flashSectorSelects;              // [R3]
      if (opDone || (!plainEe && !eData && !busWr && !opBusy))
        burst_q <= 7'h00;
      else if (busWr && eeWrite)
        burst_q <= burst_q + 7'h01;                            // [R11]
    end
  end

  // =========================================
  // array strobes and bus read data [R9]
  wire idSel   = cmdPhase && busWdata == `FECS_D_IDREAD;
  wire [7:0] rdMux = hold_q ? (busAddr[1] ? {7'h00, protF} : idValue)
                     : err_q ? 8'h20 : arrayRdata;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      progS_q <= 1'b0;
      eraS_q  <= 1'b0;
      eeS_q   <= 1'b0;
      aA_q    <= 16'h0000;
      aD_q    <= 8'h00;
      rd_q    <= 8'h00;
    end else begin
      progS_q <= fProgOk;                                       // [R9]
      eraS_q  <= sectOk || chipOk;
      eeS_q   <= busWr && eeWrite;
      if (busWr) begin
        aA_q <= busAddr;
        aD_q <= busWdata;
      end
      if (busRd) rd_q <= rdMux;                                 // [R9]
    end
  end

  // =========================================
  // outputs
  assign flashProgStb         = progS_q;
  assign flashEraseStb        = eraS_q;
  assign flashEraseMask       = eraseM_q;
  assign eepromWriteStb       = eeS_q;
  assign arrayAddr            = aA_q;
  assign arrayWdata           = aD_q;
  assign busRdata             = rd_q;
  assign errorStatusBit       = err_q;
  assign softWriteProtectMode = sdp_q;
  assign eepromPowerDown      = pdn_q;
  assign otpMode              = otp_q || idSel;
  assign eraseSuspended       = opSusp;
  // low while busy, only driven when the pin is given to it
  assign statusPinOut = !opBusy;                                // [R7]
  assign statusPinOe  = statusPinEnable;                        // [R23]
endmodule

// [verif/fecs_seq_asserts.sv]
// Purpose: port checks of the command sequencer
// Assumes: one clock, nrst synchronous active low
// Notes:   bound to every sequencer instance
module fecs_seq_asserts #(
  parameter int unsigned PWRUP_CYC = 100000
) (
  input logic       clk,
  input logic       nrst,
  input logic       busWr,
  input logic [7:0] busWdata,
  input logic [7:0] flashSectorSelects,
  input logic [3:0] eepromSectorSelects,
  input logic [7:0] flashProtect,
  input logic [3:0] eepromProtect,
  input logic       statusPinEnable,
  input logic       flashProgStb,
  input logic       flashEraseStb,
  input logic [7:0] flashEraseMask,
  input logic       eepromWriteStb,
  input logic [7:0] arrayWdata,
  input logic       errorStatusBit,
  input logic       statusPinOut,
  input logic       statusPinOe
);
  // ==========================================
  // cycles since release, saturating
  logic [31:0] upCnt_q;
  always_ff @(posedge clk) begin
    if (!nrst) upCnt_q <= 32'h0;
    else if (!(&upCnt_q)) upCnt_q <= upCnt_q + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // checks
  prog_busy_a: assert property (flashProgStb |=> !statusPinOut)
    else $error("no busy after program");
  busy_end_a: assert property (
    $fell(statusPinOut) |-> ##[1:1000] statusPinOut)
    else $error("busy never ends");
  prog_cause_a: assert property (
    flashProgStb |-> $past(busWr && (flashSectorSelects != 8'h0)))
    else $error("program without selected write");
  prog_data_a: assert property (
    flashProgStb |-> arrayWdata == $past(busWdata))
    else $error("program data differs");
  fl_prot_a: assert property (
    flashProgStb |-> $past(flashSectorSelects & flashProtect) == 8'h0)
    else $error("protected flash programmed");
  ee_prot_a: assert property (
    eepromWriteStb |-> $past(eepromSectorSelects & eepromProtect) == 4'h0)
    else $error("protected eeprom written");
  pwr_up_a: assert property (eepromWriteStb |-> upCnt_q >= PWRUP_CYC)
    else $error("eeprom written in power-up");
  erase_mask_a: assert property (
    flashEraseStb |-> flashEraseMask != 8'h0)
    else $error("erase with empty mask");
  oe_follow_a: assert property (statusPinOe == statusPinEnable)
    else $error("pin drive not as enabled");
  cover property (flashEraseStb);
  cover property (eepromWriteStb);
  cover property ($rose(errorStatusBit));
endmodule

bind fecs_sequencer fecs_seq_asserts #(.PWRUP_CYC(PWRUP_CYC)) u_chk (.*);

// [verif/fecs_mcu_model.sv]
// Purpose: 8-bit controller on the sequencer bus
// Assumes: one-cycle strobes launched at the falling edge
// Notes:   released address and data show the inverse of their last value; strobes and selects go low
`include "fecs_consts.svh"
module fecs_mcu_model (
  input  logic        clk,
  input  logic        statusPinOut,
  output logic [15:0] busAddr,
  output logic [7:0]  busWdata,
  output logic        busWr,
  output logic        busRd,
  output logic [11:0] sel
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {busAddr, busWdata, busWr, busRd, sel} = {16'hffff, 8'hff, 14'h0000};
  end
  // ==========================================
  // one bus cycle, select only while strobing
  task automatic cyc(input logic [15:0] a, input logic [7:0] d,
                     input logic w, input logic [11:0] s);
    @(negedge clk);
    {busAddr, busWdata, busWr, busRd, sel} = {a, d, w, !w, s};
    @(negedge clk);
    {busWr, busRd, sel} = 14'h0000;
    busAddr = ~a; // released: never the old value
    busWdata = ~d;
  endtask
  // prefix then command; upper bits vary
  task automatic cmd(input logic [7:0] c, input logic [11:0] s,
                     input logic [3:0] hi);
    cyc({hi, `FECS_ADDR_UNL1}, `FECS_D_UNL1, 1'b1, s);
    cyc({~hi, `FECS_ADDR_UNL2}, `FECS_D_UNL2, 1'b1, s);
    cyc({hi, `FECS_ADDR_UNL1}, c, 1'b1, s);
  endtask
  // poll ready before the next operation
  task automatic waitrdy(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 3000 && !ok; i++) begin
      @(negedge clk);
      ok = (statusPinOut === 1'b1);
    end
  endtask
endmodule

// [verif/tb_top.sv]
// Purpose: self-checking bench of the command sequencer
// Assumes: shortened counts; program busy 200 cycles
// Notes:   notes queued by the driver, retired by a watcher
`include "fecs_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] EE1 = 12'h200; // eeprom sector 1
  logic clk, nrst, busWr, busRd, statusPinEnable, rdTook, ok;
  logic flashProgStb, flashEraseStb, eepromWriteStb, errorStatusBit;
  logic eraseSuspended, statusPinOut, statusPinOe;
  logic [15:0] busAddr;
  logic [11:0] sel, evNow;
  logic [7:0]  busWdata, flashProtect, arrayRdata, idValue, d;
  logic [7:0]  flashEraseMask, arrayWdata, busRdata;
  logic [3:0]  eepromProtect, hi;
  logic [11:0] evQ[$], rdQ[$];
  int          fails, compares, cycles, seed;
  assign evNow = {1'b0, eepromWriteStb, flashEraseStb, flashProgStb,
                  flashEraseStb ? flashEraseMask : arrayWdata};
  fecs_sequencer #(.TMO_CYC(20), .PWRUP_CYC(50), .SWIN_CYC(40),
    .ERASE_CYC(100), .EEW_CYC(50)) dut (.*, .flashSectorSelects(sel[7:0]),
    .eepromSectorSelects(sel[11:8]), .arrayAddr(), .softWriteProtectMode(),
    .eepromPowerDown(), .otpMode());
  fecs_mcu_model m (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================
  // compares and verdict
  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(string n, logic e, logic g);
    chk(n, {11'h0, e}, {11'h0, g});
  endtask
  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog, and a watcher retiring notes
  always @(posedge clk) begin
    rdTook <= busRd;
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end
  always @(negedge clk) begin
    if (flashProgStb | flashEraseStb | eepromWriteStb)
      chk("event", evQ.size() ? evQ.pop_front() : 12'hfff, evNow);
    if (rdTook)
      chk("read", rdQ.size() ? rdQ.pop_front() : 12'hfff,
          {4'h0, busRdata});
  end
  initial begin
    seed = 32'hfb78;
    {nrst, flashProtect, eepromProtect} = 13'h0;
    {arrayRdata, idValue, statusPinEnable} = {8'h3c, 8'h5a, 1'b1};
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    chkb("ready", 1'b1, statusPinOut);
    m.cyc(16'h0010, 8'h11, 1'b1, EE1); // refused in power-up
    repeat (60) @(negedge clk);
    m.cyc(16'h0123, 8'h77, 1'b1, 12'h001); // plain write ignored
    arrayRdata = 8'($random(seed));
    rdQ.push_back({4'h0, arrayRdata});
    m.cyc(16'h0123, 8'h00, 1'b0, 12'h001);
    $display("test plain access done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      hi = 4'($random(seed));
      evQ.push_back({4'h1, d});
      m.cmd(`FECS_D_PROG, 12'h001 << i, hi);
      m.cyc({hi, 8'h1e, 4'(i)}, d, 1'b1, 12'h001 << i);
      m.waitrdy(ok);
      chkb("ready after program", 1'b1, ok);
    end
    $display("test program done");
    flashProtect = 8'h04;
    m.cmd(`FECS_D_PROG, 12'h004, 4'h0);
    m.cyc(16'h0040, 8'h99, 1'b1, 12'h004);
    chkb("error flag", 1'b1, errorStatusBit);
    rdQ.push_back(12'h020);
    m.cyc(16'h0040, 8'h00, 1'b0, 12'h004);
    m.cyc(16'h0777, `FECS_D_RESET, 1'b1, 12'h004);
    chkb("error cleared", 1'b0, errorStatusBit);
    flashProtect = 8'h00;
    $display("test protect done");
    m.cyc(16'h0555, `FECS_D_UNL1, 1'b1, 12'h001);
    repeat (30) @(negedge clk);
    m.cyc(16'h0aaa, `FECS_D_UNL2, 1'b1, 12'h001);
    m.cyc(16'h0555, `FECS_D_PROG, 1'b1, 12'h001);
    m.cyc(16'h0050, 8'h66, 1'b1, 12'h001); // no strobe
    $display("test timeout done");
    evQ.push_back({4'h2, 8'h08});
    m.cmd(`FECS_D_ERASE, 12'h008, 4'h3);
    m.cmd(`FECS_D_SECT, 12'h008, 4'h3);
    for (int i = 0; i < 200 && evQ.size(); i++) @(negedge clk);
    m.cyc(16'h0000, `FECS_D_SUSP, 1'b1, 12'h008);
    chkb("suspended", 1'b1, eraseSuspended);
    rdQ.push_back({4'h0, arrayRdata});
    m.cyc(16'h0100, 8'h00, 1'b0, 12'h001);
    m.cyc(16'h0000, `FECS_D_SECT, 1'b1, 12'h008);
    chkb("resumed", 1'b0, eraseSuspended);
    m.waitrdy(ok);
    chkb("ready after erase", 1'b1, ok);
    $display("test erase done");
    eepromProtect = 4'h2;
    m.cyc(16'h2345, 8'h44, 1'b1, EE1); // protected: no strobe
    eepromProtect = 4'h0;
    evQ.push_back({4'h4, 8'h5e});
    m.cyc(16'h2345, 8'h5e, 1'b1, EE1);
    m.waitrdy(ok);
    evQ.push_back({4'h4, 8'h12});
    m.cyc(16'h0555, `FECS_D_UNL1, 1'b1, EE1);
    m.cyc(16'h0123, 8'h12, 1'b1, EE1);
    m.waitrdy(ok);
    $display("test eeprom done");
    statusPinEnable = 1'b0;
    @(negedge clk);
    chkb("pin released", 1'b0, statusPinOe);
    chk("notes left", 12'h0, 12'(evQ.size() + rdQ.size()));
    give_verdict();
  end
endmodule
